//--- logic/pssram_burst.sv
`timescale 1ns/1ps

module pssram_burst (
    input wire logic [1:0] start_bits,
    input wire pssram_pkg::pssram_beat_t beat,
    input wire logic interleaved,
    output logic [1:0] low_bits
);
    import pssram_pkg::*;

    // Interleaved order flips bits by xor, linear order counts and wraps.
    assign low_bits = interleaved ? (start_bits ^ beat) : (start_bits + beat); // R13
endmodule

//--- logic/pssram_core.sv
`timescale 1ns/1ps
`include "pssram_map.svh"

// Overview of operation
// R1: Array is 256K x 36 or 512K x 18.
// R2: Back-to-back reads and writes, no wait states.
// R3: All synchronous inputs captured on rising edge.
// R4: Read data driven from output registers.
// R5: Deasserted clock qualify freezes every state; the read data buffer still pops on read_taken.
// R6: Write command plus lane selects update lanes.
// R7: Writes complete internally, self-timed.
// R8: Three chip selects select; output enable gates.
// R9: Drivers off during write data phase.
// R10: Bursts follow linear or interleaved order.
// R11: Sleep input idles device; clock may stop.
// R12: Data two qualified cycles after address.
// R13: Burst advances low two bits, wrapping.
module pssram_core #(
    parameter bit WIDE = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clock_qualify_n,
    input wire logic [`PSSRAM_NARROW_ADDR_W-1:0] address,
    input wire logic write_n,
    input wire logic advance,
    input wire logic [`PSSRAM_WIDE_LANES-1:0] byte_lane_write_selects_n,
    input wire logic chip_select_1_n,
    input wire logic chip_select_2,
    input wire logic chip_select_3_n,
    input wire logic output_enable_n,
    input wire logic interleaved_mode,
    input wire logic sleep_request,
    input wire logic [`PSSRAM_LANE_BITS*`PSSRAM_WIDE_LANES-1:0] data_in,
    output logic [`PSSRAM_LANE_BITS*`PSSRAM_WIDE_LANES-1:0] data_out,
    output logic data_oe,
    output logic read_ready,
    input wire logic read_taken,
    output logic sleeping
);
    import pssram_pkg::*;

    // =================================================================
    // Shape
    // =================================================================
    localparam int LANES = WIDE ? `PSSRAM_WIDE_LANES : `PSSRAM_NARROW_LANES;
    localparam int AW = WIDE ? `PSSRAM_WIDE_ADDR_W : `PSSRAM_NARROW_ADDR_W;
    localparam int DW = LANES * `PSSRAM_LANE_BITS;
    localparam int WORDS = 1 << AW;
    localparam int LAT = `PSSRAM_DATA_LATENCY;
    localparam int DWF = `PSSRAM_LANE_BITS * `PSSRAM_WIDE_LANES;

    logic qual;
    assign qual = !clock_qualify_n; // R5

    // =================================================================
    // Input registers
    // =================================================================
    logic [AW-1:0] addr_reg;
    logic wr_n_reg;
    logic adv_reg;
    logic [LANES-1:0] lanes_reg;
    logic sel_reg;
    logic sleep_reg;
    logic [DW-1:0] din_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= '0;
            wr_n_reg <= 1'b1;
            adv_reg <= 1'b0;
            lanes_reg <= '1;
            sel_reg <= 1'b0;
            sleep_reg <= 1'b0;
            din_reg <= '0;
        end else if (qual) begin // R5
            addr_reg <= address[AW-1:0]; // R3
            wr_n_reg <= write_n;
            adv_reg <= advance;
            lanes_reg <= byte_lane_write_selects_n[LANES-1:0];
            sel_reg <= !chip_select_1_n && chip_select_2 && !chip_select_3_n; // R8
            sleep_reg <= sleep_request; // R11
            din_reg <= data_in[DW-1:0];
        end
    end

    // =================================================================
    // Burst address
    // =================================================================
    logic [AW-1:0] base_reg;
    pssram_beat_t beat_reg;
    pssram_op_e burst_op_reg;
    logic [1:0] low_bits;
    pssram_op_e op;
    logic [AW-1:0] eff_addr;

    pssram_burst u_burst (
        .start_bits(base_reg[1:0]),
        .beat(beat_reg),
        .interleaved(interleaved_mode),
        .low_bits(low_bits)
    ); // R10

    always_comb begin
        op = PSSRAM_IDLE;
        eff_addr = addr_reg;
        if (sleep_reg) begin
            op = PSSRAM_IDLE; // R11
        end else if (adv_reg) begin
            op = burst_op_reg;
            eff_addr = {base_reg[AW-1:2], low_bits}; // R13
        end else if (sel_reg) begin
            op = wr_n_reg ? PSSRAM_READ : PSSRAM_WRITE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_reg <= '0;
            beat_reg <= '0;
            burst_op_reg <= PSSRAM_IDLE;
        end else if (qual) begin
            if (sleep_reg) begin
                burst_op_reg <= PSSRAM_IDLE;
            end else if (!adv_reg) begin
                base_reg <= addr_reg;
                beat_reg <= 2'h1;
                burst_op_reg <= op;
            end else begin
                beat_reg <= beat_reg + 2'h1; // R13
            end
        end
    end

    // =================================================================
    // Address pipeline
    // =================================================================
    pssram_op_e op_pipe_reg [LAT];
    logic [AW-1:0] addr_pipe_reg [LAT];
    logic [LANES-1:0] lane_pipe_reg [LAT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LAT; i++) begin
                op_pipe_reg[i] <= PSSRAM_IDLE;
                addr_pipe_reg[i] <= '0;
                lane_pipe_reg[i] <= '1;
            end
        end else if (qual) begin // R2
            op_pipe_reg[0] <= op;
            addr_pipe_reg[0] <= eff_addr;
            lane_pipe_reg[0] <= lanes_reg;
            for (int i = 1; i < LAT; i++) begin // R12
                op_pipe_reg[i] <= op_pipe_reg[i-1];
                addr_pipe_reg[i] <= addr_pipe_reg[i-1];
                lane_pipe_reg[i] <= lane_pipe_reg[i-1];
            end
        end
    end

    // The write data registered now belongs to the address one cycle back.
    pssram_op_e tail_op;
    logic [AW-1:0] tail_addr;
    logic [LANES-1:0] tail_lanes;
    assign tail_op = op_pipe_reg[LAT-2];
    assign tail_addr = addr_pipe_reg[LAT-2];
    assign tail_lanes = lane_pipe_reg[LAT-2];

    // =================================================================
    // Array
    // =================================================================
    // Each lane keeps its own storage so that every lane has a single writer.
    logic [DW-1:0] mem_word;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [`PSSRAM_LANE_BITS-1:0] lane_mem_reg [WORDS]; // R1

            always_ff @(posedge ref_clk) begin
                if (qual && tail_op == PSSRAM_WRITE && !tail_lanes[g]) begin // R6 R7
                    lane_mem_reg[tail_addr] <=
                        din_reg[g*`PSSRAM_LANE_BITS +: `PSSRAM_LANE_BITS];
                end
            end

            assign mem_word[g*`PSSRAM_LANE_BITS +: `PSSRAM_LANE_BITS] = lane_mem_reg[tail_addr];
        end
    endgenerate

    // =================================================================
    // Output registers
    // =================================================================
    logic [DW-1:0] dout_reg;
    logic drive_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_reg <= '0;
            drive_reg <= 1'b0;
        end else if (qual) begin
            if (tail_op == PSSRAM_READ) begin
                dout_reg <= mem_word; // R4
            end
            drive_reg <= (tail_op == PSSRAM_READ); // R9
        end
    end

    assign data_out = DWF'(dout_reg);
    assign data_oe = drive_reg && !output_enable_n; // R8
    assign sleeping = sleep_reg;

    // =================================================================
    // Read data buffer
    // =================================================================
    logic read_push;
    logic read_push_ready;
    logic [DW-1:0] read_word;
    assign read_push = qual && drive_reg;

    pssram_fifo #(
        .WIDTH(DW),
        .DEPTH(`PSSRAM_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(read_push),
        .in_ready(read_push_ready),
        .in_data(dout_reg),
        .out_valid(read_ready),
        .out_ready(read_taken),
        .out_data(read_word)
    );

    // =================================================================
    // Checks
    // =================================================================
    sequence s_read_issued;
        qual && op == PSSRAM_READ;
    endsequence

    sequence s_read_staged;
        tail_op == PSSRAM_READ;
    endsequence

    sequence s_read_launch;
        qual && tail_op == PSSRAM_READ;
    endsequence

    property p_read_staged;
        @(posedge ref_clk) disable iff (!rst_n)
        s_read_issued |=> s_read_staged;
    endproperty
    a_read_staged: assert property (p_read_staged) else $error("Read not staged."); // R12

    property p_read_drives;
        @(posedge ref_clk) disable iff (!rst_n)
        s_read_launch |=> drive_reg;
    endproperty
    a_read_drives: assert property (p_read_drives) else $error("Read not driven."); // R12

    property p_write_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        (qual && tail_op == PSSRAM_WRITE) |=> !drive_reg;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("Drive in write."); // R9

    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
        !qual |=> $stable(dout_reg) && $stable(drive_reg) && $stable(addr_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved unqualified."); // R5

    property p_oe_gate;
        @(posedge ref_clk) disable iff (!rst_n)
        output_enable_n |-> !data_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("Output not gated."); // R8

    property p_deselect_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        (!sel_reg && !adv_reg) |-> op == PSSRAM_IDLE;
    endproperty
    a_deselect_idle: assert property (p_deselect_idle) else $error("Op deselected."); // R8

    property p_sleep_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        sleep_reg |-> op == PSSRAM_IDLE;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("Op while asleep."); // R11

    property p_burst_high;
        @(posedge ref_clk) disable iff (!rst_n)
        (adv_reg && !sleep_reg) |-> eff_addr[AW-1:2] == base_reg[AW-1:2];
    endproperty
    a_burst_high: assert property (p_burst_high) else $error("Burst left block."); // R13

    property p_input_capture;
        @(posedge ref_clk) disable iff (!rst_n)
        qual |=> addr_reg == $past(address[AW-1:0]);
    endproperty
    a_input_capture: assert property (p_input_capture) else $error("Input missed."); // R3

    property p_back_to_back;
        @(posedge ref_clk) disable iff (!rst_n)
        (qual && op != PSSRAM_IDLE) |=> op_pipe_reg[0] == $past(op);
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("Op dropped."); // R2

    property p_fifo_room;
        @(posedge ref_clk) disable iff (!rst_n)
        read_push |-> read_push_ready;
    endproperty
    a_fifo_room: assert property (p_fifo_room) else $error("Read buffer overrun.");

    property p_buffer_word;
        @(posedge ref_clk) disable iff (!rst_n)
        (read_push && !read_ready) |=> read_word == $past(dout_reg);
    endproperty
    a_buffer_word: assert property (p_buffer_word) else $error("Buffered word wrong."); // R4
endmodule

//--- logic/pssram_fifo.sv
`timescale 1ns/1ps

module pssram_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- logic/pssram_map.svh
`ifndef PSSRAM_MAP_SVH
`define PSSRAM_MAP_SVH

// =====================================================================
// Array shape
// =====================================================================
`define PSSRAM_WIDE_ADDR_W 18
`define PSSRAM_NARROW_ADDR_W 19
`define PSSRAM_LANE_BITS 9
`define PSSRAM_WIDE_LANES 4
`define PSSRAM_NARROW_LANES 2

// =====================================================================
// Pipeline and burst
// =====================================================================
`define PSSRAM_DATA_LATENCY 2
`define PSSRAM_BURST_LEN 4
`define PSSRAM_FIFO_DEPTH 16

`endif

//--- logic/pssram_pkg.sv
package pssram_pkg;

    typedef enum logic [1:0] {
        PSSRAM_IDLE,
        PSSRAM_READ,
        PSSRAM_WRITE
    } pssram_op_e;

    typedef logic [1:0] pssram_beat_t;

endpackage

//--- verification/pssram_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// Memory controller model driving the synchronous bus
module pssram_ctrl_model (
    input wire logic ref_clk,
    output logic clock_qualify_n,
    output logic [18:0] address,
    output logic write_n,
    output logic advance,
    output logic [3:0] byte_lane_write_selects_n,
    output logic chip_select_1_n,
    output logic chip_select_2,
    output logic chip_select_3_n,
    output logic [35:0] data_in
);
    logic [35:0] wdata_reg;

    initial begin
        {clock_qualify_n, address, write_n, advance} = '0;
        byte_lane_write_selects_n = 4'hF;
        {chip_select_1_n, chip_select_2, chip_select_3_n} = 3'h5;
        data_in = '0;
        wdata_reg = '0;
    end

    // Write data is taken on the qualified edge after its address and stalls with the core.
    always @(posedge ref_clk) begin
        if (!clock_qualify_n) begin
            data_in <= wdata_reg;
        end
    end

    // One bus cycle; a frozen cycle leaves the pending write data alone.
    task automatic op(input logic wr, adv, input logic [1:0] sel, input logic frz,
                      input logic [18:0] a, input logic [3:0] be_n, input logic [35:0] d);
        @(posedge ref_clk);
        clock_qualify_n <= frz;
        address <= a;
        write_n <= !wr;
        advance <= adv;
        byte_lane_write_selects_n <= be_n;
        chip_select_1_n <= (sel == 2'h1);
        chip_select_2 <= (sel != 2'h2);
        chip_select_3_n <= (sel == 2'h3);
        if (!frz) wdata_reg <= wr ? d : ~wdata_reg;
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
`include "pssram_map.svh"

// ==========================================================
// Bench for the pipelined memory core
module tb;
    localparam logic [35:0] LANE02 = {9'h000, 9'h1FF, 9'h000, 9'h1FF};
    logic ref_clk = 0, rst_n = 0, output_enable_n = 0, interleaved_mode = 0;
    logic sleep_request = 0, read_taken = 1;
    logic clock_qualify_n, write_n, advance, chip_select_1_n, chip_select_2, chip_select_3_n;
    logic [18:0] address;
    logic [3:0] byte_lane_write_selects_n;
    logic [35:0] data_in, data_out;
    logic data_oe, read_ready, sleeping;
    logic ev_v [4];
    logic [35:0] ev_d [4];
    int num_errors = 0, checks = 0;

    pssram_core #(.WIDE(1'b1)) DUT (.ref_clk, .rst_n, .clock_qualify_n, .address, .write_n,
        .advance, .byte_lane_write_selects_n, .chip_select_1_n, .chip_select_2,
        .chip_select_3_n, .output_enable_n, .interleaved_mode, .sleep_request, .data_in,
        .data_out, .data_oe, .read_ready, .read_taken, .sleeping);
    pssram_ctrl_model ctrl (.ref_clk, .clock_qualify_n, .address, .write_n, .advance,
        .byte_lane_write_selects_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
        .data_in);

    initial forever #2.5 ref_clk = ~ref_clk;

    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        num_errors++;
    endtask
    task automatic check_bit(input logic g, input logic e, input string m);
        checks++;
        if (g !== e) fail(m);
    endtask
    task automatic check_word(input logic [35:0] g, input logic [35:0] e, input string m);
        checks++;
        if (g !== e) fail(m);
    endtask
    task automatic check_count(input int g, input int e, input string m);
        checks++;
        if (g != e) fail(m);
    endtask
    task automatic results();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [35:0] pat(input int i);
        return {4'(i), 8'hC3, 24'(i * 24'h00A5B7)};
    endfunction

    // One bus cycle; a read that the core must answer enters the expectation pipe.
    task automatic go(input logic wr, adv, input logic [1:0] sel, input logic frz,
                      input logic [18:0] a, input logic [35:0] d, input logic [3:0] be_n = 4'h0);
        ctrl.op(wr, adv, sel, frz, a, be_n, d);
        if (!frz) begin
            ev_v[0] <= !wr && sel == 2'h0 && !sleep_request;
            ev_d[0] <= d;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) go(0, 0, 2'h1, 0, 19'h0, 36'h0);
    endtask

    // Expected reads move one stage per qualified edge and stand after the third one.
    always @(posedge ref_clk) begin
        if (!clock_qualify_n) begin
            for (int i = 1; i < 4; i++) begin
                ev_v[i] <= ev_v[i-1];
                ev_d[i] <= ev_d[i-1];
            end
        end
        #1;
        if (rst_n) begin
            check_bit(data_oe, ev_v[3] && !output_enable_n, "drive enable");
            if (ev_v[3]) check_word(data_out, ev_d[3], "read data");
        end
    end

    task automatic s_pipe();
        go(1, 0, 0, 0, 19'h10, pat(0));
        go(1, 0, 0, 0, 19'h11, pat(1));
        idle(2);
        go(0, 0, 0, 0, 19'h10, pat(0));
        go(1, 0, 0, 0, 19'h12, pat(2));
        go(0, 0, 0, 0, 19'h11, pat(1));
        go(1, 0, 0, 0, 19'h11, pat(3), 4'hA);
        go(0, 0, 0, 0, 19'h10, pat(0));
        idle(2);
        go(0, 0, 0, 0, 19'h11, (pat(3) & LANE02) | (pat(1) & ~LANE02));
        go(0, 0, 0, 0, 19'h12, pat(2));
        idle(5);
    endtask

    task automatic s_freeze();
        go(1, 0, 0, 0, 19'h13, pat(4));
        repeat (2) go(0, 0, 0, 1, 19'h13, pat(0));
        idle(4);
        go(0, 0, 0, 0, 19'h13, pat(4));
        idle(1);
        repeat (3) go(0, 0, 0, 1, 19'h10, pat(0));
        idle(5);
    endtask

    task automatic s_select();
        for (int s = 1; s < 4; s++) begin
            go(1, 0, 2'(s), 0, 19'h10, pat(9));
            go(0, 0, 2'(s), 0, 19'h10, pat(9));
        end
        idle(3);
        output_enable_n <= 1;
        go(0, 0, 0, 0, 19'h10, pat(0));
        idle(4);
        output_enable_n <= 0;
        go(0, 0, 0, 0, 19'h10, pat(0));
        idle(5);
    endtask

    task automatic s_burst();
        for (int j = 0; j < 4; j++) go(1, 0, 0, 0, 19'h20 + 19'(j), pat(8 + j));
        idle(4);
        for (int m = 0; m < 2; m++) begin
            interleaved_mode <= m[0];
            idle(1);
            for (int k = 0; k < 4; k++) begin
                go(0, k > 0, 0, 0, 19'h21, pat(8 + (m ? (1 ^ k) : ((1 + k) & 3))));
            end
            idle(5);
        end
    endtask

    task automatic s_sleep();
        sleep_request <= 1;
        repeat (20) if (sleeping !== 1'b1) begin idle(1); #1; end
        check_bit(sleeping, 1'b1, "sleep entry");
        go(1, 0, 0, 0, 19'h10, pat(7));
        go(0, 0, 0, 0, 19'h10, pat(7));
        idle(3);
        sleep_request <= 0;
        repeat (20) if (sleeping !== 1'b0) begin idle(1); #1; end
        check_bit(sleeping, 1'b0, "sleep exit");
        idle(2);
        go(0, 0, 0, 0, 19'h10, pat(0));
        idle(5);
    endtask

    task automatic s_buffer();
        int n = 0;
        read_taken <= 1;
        idle(40);
        read_taken <= 0;
        repeat (16) go(0, 0, 0, 0, 19'h10, pat(0));
        idle(6);
        read_taken <= 1;
        repeat (40) begin
            #1;
            if (read_ready !== 1'b1) break;
            n++;
            idle(1);
        end
        check_count(n, `PSSRAM_FIFO_DEPTH, "buffer pops");
        idle(1);
        read_taken <= 0;
    endtask

    initial begin
        foreach (ev_v[i]) ev_v[i] = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1;
        idle(2);
        s_pipe();
        s_freeze();
        s_select();
        s_burst();
        s_sleep();
        s_buffer();
        results();
    end

    initial begin
        #200000;
        fail("timeout");
        results();
    end
endmodule
